/* modbus_slave_consts.vh */
// Constants for the Modbus slave request handler: codes, sizes and states.
`ifndef MODBUS_SLAVE_CONSTS_VH
`define MODBUS_SLAVE_CONSTS_VH

`define FC_READ_HOLD     8'h03
`define FC_WRITE_MULTI   8'h10
`define FC_ACCESS_LOG    8'h46
`define FC_EXC_FLAG      8'h80
`define BCAST_ADDR       8'h00

`define EXC_NONE         8'h00
`define EXC_ILL_FUNC     8'h01
`define EXC_ILL_ADDR     8'h02
`define EXC_ILL_VALUE    8'h03

`define MIN_FRAME_LEN    9'h004
`define READ_QUERY_LEN   9'h008
`define WRITE_HDR_LEN    9'h009
`define LOG_QUERY_LEN    9'h004
`define MAX_POINTS       16'h007D
`define RX_DEPTH         9'h104
`define TX_DEPTH         9'h0FD
`define WDATA_BASE       9'h007
`define RDATA_BASE       8'h03
`define SHORT_RESP_LEN   8'h06
`define EXC_RESP_LEN     8'h03

`define CRC_INIT         16'hFFFF
`define CRC_POLY         16'hA001

`define ST_IDLE          3'h0
`define ST_DECODE        3'h1
`define ST_ACC_REQ       3'h2
`define ST_ACC_WAIT      3'h3
`define ST_FINISH        3'h4
`define ST_SEND          3'h5
`define ST_CRC_LO        3'h6
`define ST_CRC_HI        3'h7

`endif

/* crc16_acc.v */
// Running Modbus CRC-16 accumulator, one byte per enable.
`timescale 1ns/1ns
`include "modbus_slave_consts.vh"

module crc16_acc (
   input  wire        clock,
   input  wire        rst_n,
   input  wire        clear,
   input  wire        en,
   input  wire [7:0]  data,
   output reg  [15:0] crc_r
);

   function [15:0] crc_step;
      input [15:0] c_in;
      input [7:0]  d;
      reg   [15:0] c;
      integer      i;
      begin
         c = c_in ^ {8'h00, d};
         for (i = 0; i < 8; i = i + 1) begin
            if (c[0])
               c = (c >> 1) ^ `CRC_POLY;
            else
               c = c >> 1;
         end
         crc_step = c;
      end
   endfunction

   // Clear wins over enable so a new frame never inherits old residue.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         crc_r <= `CRC_INIT;
      else if (clear)
         crc_r <= `CRC_INIT;
      else if (en)
         crc_r <= crc_step(crc_r, data);
   end

endmodule

/* modbus_slave_access_log_and_errors.v */
// Modbus RTU slave request handler with access log and exception replies.
`timescale 1ns/1ns
`include "modbus_slave_consts.vh"

module modbus_slave_access_log_and_errors (
   input  wire        clock,
   input  wire        resetn,
   input  wire [7:0]  slave_addr,
   input  wire [7:0]  rx_data,
   input  wire        rx_valid,
   input  wire        rx_parity_err,
   input  wire        rx_framing_err,
   input  wire        rx_overrun_err,
   input  wire        rx_frame_end,
   input  wire        tx_ready,
   input  wire [15:0] acc_rdata,
   input  wire        acc_ok,
   input  wire        acc_value_bad,
   output reg  [7:0]  tx_data_r,
   output reg         tx_valid_r,
   output reg         acc_req_r,
   output reg         acc_we_r,
   output reg  [15:0] acc_addr_r,
   output reg  [15:0] acc_wdata_r,
   output reg  [15:0] comm_error_counter_r,
   output reg         rx_error_r,
   output reg         busy_r
);

   function [15:0] be16;
      input [7:0] hi;
      input [7:0] lo;
      begin
         be16 = {hi, lo};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   reg  [1:0]  rst_sync_r;
   wire        rst_n;

   always @(posedge clock or negedge resetn) begin
      if (!resetn)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   ////////////////////////////////////////////////////////////////////////
   reg  [7:0]  rx_mem [0:`RX_DEPTH-1];
   reg  [7:0]  tx_mem [0:`TX_DEPTH-1];
   reg  [2:0]  state_r;
   reg  [8:0]  rx_cnt_r;
   reg  [8:0]  frame_len_r;
   reg         rx_err_r;
   reg         rx_ovf_r;
   reg         busy_drop_r;
   reg  [7:0]  func_r;
   reg  [7:0]  exc_r;
   reg  [15:0] start_r;
   reg  [15:0] count_r;
   reg  [6:0]  idx_r;
   reg  [7:0]  ok_cnt_r;
   reg  [15:0] first_ok_r;
   reg  [15:0] log_start_r;
   reg  [7:0]  log_count_r;
   reg  [7:0]  tx_len_r;
   reg  [7:0]  sidx_r;
   reg         bcast_r;

   wire [15:0] rx_crc;
   wire [15:0] tx_crc;
   wire        rx_take;
   reg         tx_crc_en;
   reg  [7:0]  tx_crc_byte;
   wire        tracked;
   wire [7:0]  final_exc;
   wire        frame_bad;
   wire [15:0] q_start;
   wire [15:0] q_count;
   wire [8:0]  wr_len;
   wire [8:0]  wr_pos;

   assign rx_take   = rx_valid && (state_r == `ST_IDLE) && !busy_drop_r;
   assign q_start   = be16(rx_mem[2], rx_mem[3]);
   assign q_count   = be16(rx_mem[4], rx_mem[5]);
   assign wr_len    = `WRITE_HDR_LEN + {q_count[7:0], 1'b0};
   assign wr_pos    = `WDATA_BASE + {1'b0, idx_r, 1'b0};
   assign tracked   = (func_r == `FC_READ_HOLD) ||
                      (func_r == `FC_WRITE_MULTI);
   // A tracked request that reached no register at all is an address error.
   assign final_exc = (exc_r != `EXC_NONE) ? exc_r :
                      (tracked && ok_cnt_r == 8'h00) ? `EXC_ILL_ADDR :
                      `EXC_NONE;
   assign frame_bad = rx_err_r || rx_ovf_r ||
                      (rx_cnt_r < `MIN_FRAME_LEN) ||
                      (rx_crc != 16'h0000);

   crc16_acc u_rx_crc (
      .clock (clock),
      .rst_n (rst_n),
      .clear (rx_frame_end),
      .en    (rx_take),
      .data  (rx_data),
      .crc_r (rx_crc)
   );

   crc16_acc u_tx_crc (
      .clock (clock),
      .rst_n (rst_n),
      .clear (state_r == `ST_FINISH),
      .en    (tx_crc_en),
      .data  (tx_crc_byte),
      .crc_r (tx_crc)
   );

   always @* begin
      tx_crc_en   = (state_r == `ST_SEND) && !tx_valid_r;
      tx_crc_byte = tx_mem[sidx_r];
   end

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r              <= `ST_IDLE;
         rx_cnt_r             <= 9'h000;
         frame_len_r          <= 9'h000;
         rx_err_r             <= 1'b0;
         rx_ovf_r             <= 1'b0;
         busy_drop_r          <= 1'b0;
         func_r               <= 8'h00;
         exc_r                <= `EXC_NONE;
         start_r              <= 16'h0000;
         count_r              <= 16'h0000;
         idx_r                <= 7'h00;
         ok_cnt_r             <= 8'h00;
         first_ok_r           <= 16'h0000;
         log_start_r          <= 16'h0000;
         log_count_r          <= 8'h00;
         tx_len_r             <= 8'h00;
         sidx_r               <= 8'h00;
         bcast_r              <= 1'b0;
         tx_data_r            <= 8'h00;
         tx_valid_r           <= 1'b0;
         acc_req_r            <= 1'b0;
         acc_we_r             <= 1'b0;
         acc_addr_r           <= 16'h0000;
         acc_wdata_r          <= 16'h0000;
         comm_error_counter_r <= 16'h0000;
         rx_error_r           <= 1'b0;
         busy_r               <= 1'b0;
      end else begin
         acc_req_r  <= 1'b0;
         rx_error_r <= 1'b0;
         busy_r     <= (state_r != `ST_IDLE);
         // A frame that starts while busy is dropped whole, with no reply.
         if (rx_valid && state_r != `ST_IDLE)
            busy_drop_r <= 1'b1;
         else if (rx_frame_end)
            busy_drop_r <= 1'b0;
         if (rx_take) begin
            if (rx_cnt_r < `RX_DEPTH) begin
               rx_mem[rx_cnt_r] <= rx_data;
               rx_cnt_r         <= rx_cnt_r + 9'h001;
            end else begin
               rx_ovf_r <= 1'b1;
            end
            if (rx_parity_err || rx_framing_err || rx_overrun_err)
               rx_err_r <= 1'b1;
         end
         case (state_r)
            `ST_IDLE: begin
               if (rx_frame_end && !busy_drop_r) begin
                  rx_cnt_r <= 9'h000;
                  rx_err_r <= 1'b0;
                  rx_ovf_r <= 1'b0;
                  if (frame_bad) begin
                     if (rx_cnt_r != 9'h000) begin
                        // Counted and flagged on rx_error_r; the drive keeps running.
                        comm_error_counter_r <= comm_error_counter_r +
                                                16'h0001;
                        rx_error_r           <= 1'b1;
                     end
                  end else if (rx_mem[0] == slave_addr ||
                               rx_mem[0] == `BCAST_ADDR) begin
                     frame_len_r <= rx_cnt_r;
                     state_r     <= `ST_DECODE;
                  end
               end
            end
            `ST_DECODE: begin
               func_r     <= rx_mem[1];
               bcast_r    <= (rx_mem[0] == `BCAST_ADDR);
               start_r    <= q_start;
               count_r    <= q_count;
               idx_r      <= 7'h00;
               ok_cnt_r   <= 8'h00;
               exc_r      <= `EXC_NONE;
               tx_mem[0]  <= rx_mem[0];
               tx_mem[1]  <= rx_mem[1];
               state_r    <= `ST_FINISH;
               case (rx_mem[1])
                  `FC_READ_HOLD: begin
                     tx_mem[2] <= {q_count[6:0], 1'b0};
                     tx_len_r  <= `RDATA_BASE + {q_count[6:0], 1'b0};
                     if (frame_len_r != `READ_QUERY_LEN ||
                         q_count == 16'h0000 || q_count > `MAX_POINTS)
                        exc_r <= `EXC_ILL_VALUE;
                     else
                        state_r <= `ST_ACC_REQ;
                  end
                  `FC_WRITE_MULTI: begin
                     tx_mem[2] <= rx_mem[2];
                     tx_mem[3] <= rx_mem[3];
                     tx_mem[4] <= rx_mem[4];
                     tx_mem[5] <= rx_mem[5];
                     tx_len_r  <= `SHORT_RESP_LEN;
                     if (q_count == 16'h0000 || q_count > `MAX_POINTS ||
                         frame_len_r != wr_len ||
                         rx_mem[6] != {q_count[6:0], 1'b0})
                        exc_r <= `EXC_ILL_VALUE;
                     else
                        state_r <= `ST_ACC_REQ;
                  end
                  `FC_ACCESS_LOG: begin
                     // Broadcast of this query is left to the master to avoid.
                     tx_mem[2] <= log_start_r[15:8];
                     tx_mem[3] <= log_start_r[7:0];
                     tx_mem[4] <= 8'h00;
                     tx_mem[5] <= log_count_r;
                     tx_len_r  <= `SHORT_RESP_LEN;
                     if (frame_len_r != `LOG_QUERY_LEN)
                        exc_r <= `EXC_ILL_VALUE;
                  end
                  default:
                     exc_r <= `EXC_ILL_FUNC;
               endcase
            end
            `ST_ACC_REQ: begin
               acc_req_r   <= 1'b1;
               acc_we_r    <= (func_r == `FC_WRITE_MULTI);
               // Wire addresses pass through already offset by 40001.
               acc_addr_r  <= start_r + {9'h000, idx_r};
               acc_wdata_r <= be16(rx_mem[wr_pos], rx_mem[wr_pos + 9'h001]);
               state_r     <= `ST_ACC_WAIT;
            end
            `ST_ACC_WAIT: begin
               if (!acc_we_r) begin
                  tx_mem[`RDATA_BASE + {idx_r, 1'b0}] <=
                     acc_ok ? acc_rdata[15:8] : 8'h00;
                  tx_mem[`RDATA_BASE + {idx_r, 1'b0} + 8'h01] <=
                     acc_ok ? acc_rdata[7:0] : 8'h00;
               end
               if (acc_ok) begin
                  ok_cnt_r <= ok_cnt_r + 8'h01;
                  if (ok_cnt_r == 8'h00)
                     first_ok_r <= acc_addr_r;
               end
               if (acc_we_r && acc_value_bad) begin
                  exc_r   <= `EXC_ILL_VALUE;
                  state_r <= `ST_FINISH;
               end else if ({9'h000, idx_r} == count_r - 16'h0001) begin
                  state_r <= `ST_FINISH;
               end else begin
                  idx_r   <= idx_r + 7'h01;
                  state_r <= `ST_ACC_REQ;
               end
            end
            `ST_FINISH: begin
               if (func_r != `FC_ACCESS_LOG) begin
                  if (tracked && final_exc == `EXC_NONE) begin
                     log_start_r <= first_ok_r;
                     log_count_r <= ok_cnt_r;
                  end else begin
                     log_start_r <= 16'h0000;
                     log_count_r <= 8'h00;
                  end
               end
               if (final_exc != `EXC_NONE) begin
                  tx_mem[1] <= func_r | `FC_EXC_FLAG;
                  tx_mem[2] <= final_exc;
                  tx_len_r  <= `EXC_RESP_LEN;
               end
               sidx_r  <= 8'h00;
               state_r <= bcast_r ? `ST_IDLE : `ST_SEND;
            end
            `ST_SEND: begin
               if (!tx_valid_r) begin
                  tx_data_r  <= tx_mem[sidx_r];
                  tx_valid_r <= 1'b1;
               end else if (tx_ready) begin
                  tx_valid_r <= 1'b0;
                  sidx_r     <= sidx_r + 8'h01;
                  if (sidx_r == tx_len_r - 8'h01)
                     state_r <= `ST_CRC_LO;
               end
            end
            `ST_CRC_LO: begin
               if (!tx_valid_r) begin
                  tx_data_r  <= tx_crc[7:0];
                  tx_valid_r <= 1'b1;
               end else if (tx_ready) begin
                  tx_valid_r <= 1'b0;
                  state_r    <= `ST_CRC_HI;
               end
            end
            `ST_CRC_HI: begin
               if (!tx_valid_r) begin
                  tx_data_r  <= tx_crc[15:8];
                  tx_valid_r <= 1'b1;
               end else if (tx_ready) begin
                  tx_valid_r <= 1'b0;
                  state_r    <= `ST_IDLE;
               end
            end
            default:
               state_r <= `ST_IDLE;
         endcase
      end
   end

endmodule

/* modbus_slave_monitor.sv */
// Port-level assertion checker for the Modbus slave request handler.
`timescale 1ns/1ns
module modbus_slave_monitor (
   input wire        clock,
   input wire        resetn,
   input wire [7:0]  slave_addr,
   input wire [7:0]  rx_data,
   input wire        rx_valid,
   input wire        rx_parity_err,
   input wire        rx_framing_err,
   input wire        rx_overrun_err,
   input wire        rx_frame_end,
   input wire        tx_ready,
   input wire [7:0]  tx_data_r,
   input wire        tx_valid_r,
   input wire        acc_req_r,
   input wire [15:0] acc_addr_r,
   input wire [15:0] comm_error_counter_r,
   input wire        rx_error_r
);
   reg [8:0]  nb_r;
   reg [7:0]  addr_r;
   reg [7:0]  fc_r;
   reg [15:0] start_r;
   reg        bad_r;
   reg        first_r;
   reg        exc_r;
   reg [3:0]  ntx_r;
   reg [9:0]  quiet_r;
   wire       bad_now = bad_r | (nb_r != 9'h000 && nb_r < 9'h004);
   wire       rx_err = rx_parity_err | rx_framing_err | rx_overrun_err;

   // Tracks the last frame so each reply byte can be tied to its query.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         nb_r <= 9'h000;
         addr_r <= 8'h00;
         fc_r <= 8'h00;
         start_r <= 16'h0000;
         bad_r <= 1'b0;
         first_r <= 1'b0;
         exc_r <= 1'b0;
         ntx_r <= 4'h0;
         quiet_r <= 10'h000;
      end else begin
         if (rx_valid) begin
            nb_r <= nb_r + 9'h001;
            if (nb_r == 9'h000)
               addr_r <= rx_data;
            if (nb_r == 9'h001)
               fc_r <= rx_data;
            if (nb_r == 9'h002)
               start_r[15:8] <= rx_data;
            if (nb_r == 9'h003)
               start_r[7:0] <= rx_data;
            if (rx_err)
               bad_r <= 1'b1;
         end
         if (rx_frame_end) begin
            nb_r <= 9'h000;
            bad_r <= 1'b0;
            ntx_r <= 4'h0;
            first_r <= 1'b1;
            quiet_r <= (bad_now || addr_r != slave_addr) ? 10'h190 : 10'h000;
         end else if (quiet_r != 10'h000) begin
            quiet_r <= quiet_r - 10'h001;
         end
         if (acc_req_r)
            first_r <= 1'b0;
         if (tx_valid_r && tx_ready) begin
            // Saturates so a long read reply never looks like a new one.
            if (ntx_r != 4'hF)
               ntx_r <= ntx_r + 4'h1;
            if (ntx_r == 4'h1)
               exc_r <= tx_data_r[7];
         end
      end
   end

   ////////////////////////////////////////
   sequence s_bad_end;
      rx_frame_end && bad_now;
   endsequence
   sequence s_err_report;
      ##[1:3] rx_error_r;
   endsequence

   a_err_reported: assert property (
      @(posedge clock) disable iff (!resetn) s_bad_end |-> s_err_report)
      else $error("flagged frame not reported");
   a_err_step: assert property (
      @(posedge clock) disable iff (!resetn) $changed(comm_error_counter_r)
      |-> comm_error_counter_r == $past(comm_error_counter_r) + 16'h0001)
      else $error("error counter moved by other than one");
   a_err_pulse: assert property (
      @(posedge clock) disable iff (!resetn) rx_error_r |=> !rx_error_r)
      else $error("error pulse longer than one cycle");
   a_stay_quiet: assert property (
      @(posedge clock) disable iff (!resetn) quiet_r != 10'h000 |-> !tx_valid_r)
      else $error("reply to a frame that needs silence");
   a_addr_echo: assert property (
      @(posedge clock) disable iff (!resetn)
      tx_valid_r && ntx_r == 4'h0 |-> tx_data_r == addr_r)
      else $error("reply address differs from query");
   a_func_echo: assert property (
      @(posedge clock) disable iff (!resetn) tx_valid_r && ntx_r == 4'h1
      |-> tx_data_r == fc_r || tx_data_r == (fc_r | 8'h80))
      else $error("reply function byte wrong");
   a_exc_code: assert property (
      @(posedge clock) disable iff (!resetn) tx_valid_r && ntx_r == 4'h2
      && exc_r |-> tx_data_r inside {8'h01, 8'h02, 8'h03})
      else $error("exception code out of set");
   a_bad_func: assert property (
      @(posedge clock) disable iff (!resetn) tx_valid_r && ntx_r == 4'h2
      && exc_r && !(fc_r inside {8'h03, 8'h10, 8'h46}) |-> tx_data_r == 8'h01)
      else $error("unknown function not code one");
   a_wire_addr: assert property (
      @(posedge clock) disable iff (!resetn)
      acc_req_r && first_r |-> acc_addr_r == start_r)
      else $error("access address not the wire address");
   a_tx_hold: assert property (
      @(posedge clock) disable iff (!resetn)
      tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
      else $error("reply byte changed before taken");
endmodule

bind modbus_slave_access_log_and_errors modbus_slave_monitor u_mon (
   .clock, .resetn, .slave_addr, .rx_data, .rx_valid, .rx_parity_err,
   .rx_framing_err, .rx_overrun_err, .rx_frame_end, .tx_ready, .tx_data_r,
   .tx_valid_r, .acc_req_r, .acc_addr_r, .comm_error_counter_r, .rx_error_r
);

/* modbus_master_model.sv */
// Serial master model: sends request frames and collects reply bytes.
`timescale 1ns/1ns
`include "modbus_slave_consts.vh"
module modbus_master_model (
   input  wire       clock,
   input  wire       slow,
   input  wire [7:0] tx_data_r,
   input  wire       tx_valid_r,
   output reg  [7:0] rx_data,
   output reg        rx_valid,
   output reg        rx_parity_err,
   output reg        rx_framing_err,
   output reg        rx_overrun_err,
   output reg        rx_frame_end,
   output reg        tx_ready
);
   logic [7:0] got[$];

   // Error flags idle high: they only mean something beside a byte pulse.
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      rx_parity_err = 1'b1;
      rx_framing_err = 1'b1;
      rx_overrun_err = 1'b1;
      rx_frame_end = 1'b0;
      tx_ready = 1'b1;
   end

   function automatic [15:0] crc16(input logic [7:0] f[$]);
      logic [15:0] c;
      c = `CRC_INIT;
      foreach (f[i]) begin
         c = c ^ {8'h00, f[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   // Error kind: 1 parity, 2 framing, 3 overrun on the last byte, 4 bad CRC.
   task automatic send(input logic [7:0] f[$], input int err);
      logic [15:0] c;
      int          n;
      if (f.size() > 1 && f[0] == `BCAST_ADDR && f[1] == `FC_ACCESS_LOG)
         return;
      c = crc16(f) ^ ((err == 4) ? 16'h0001 : 16'h0000);
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      n = f.size();
      foreach (f[i]) begin
         @(negedge clock);
         rx_data = f[i];
         rx_valid = 1'b1;
         rx_parity_err = (err == 1) && (i == n - 1);
         rx_framing_err = (err == 2) && (i == n - 1);
         rx_overrun_err = (err == 3) && (i == n - 1);
         @(negedge clock);
         rx_valid = 1'b0;
         rx_data = ~rx_data;
         {rx_parity_err, rx_framing_err, rx_overrun_err} = 3'h7;
      end
      repeat (3) @(negedge clock);
      rx_frame_end = 1'b1;
      @(negedge clock);
      rx_frame_end = 1'b0;
   endtask

   always @(negedge clock)
      tx_ready <= slow ? ~tx_ready : 1'b1;
   always @(posedge clock)
      if (tx_valid_r && tx_ready)
         got.push_back(tx_data_r);
endmodule

/* tb_top.sv */
// Self-checking testbench for the Modbus slave request handler.
`timescale 1ns/1ns
`include "modbus_slave_consts.vh"
module tb_top;
   localparam [7:0] SA = 8'h19;
   logic        clock;
   logic        resetn = 1'b0;
   logic        slow = 1'b0;
   logic        acc_ok = 1'b0;
   logic        acc_value_bad = 1'b0;
   logic [15:0] acc_rdata = 16'h0000;
   logic [1:0]  ok_mask = 2'b00;
   logic [7:0]  f[$];
   logic [7:0]  e[$];
   logic [7:0]  none[$];
   wire  [7:0]  rx_data;
   wire  [7:0]  tx_data_r;
   wire         rx_valid, rx_parity_err, rx_framing_err, rx_overrun_err;
   wire         rx_frame_end, tx_ready, tx_valid_r, acc_req_r, acc_we_r;
   wire         rx_error_r, busy_r;
   wire  [15:0] acc_addr_r, acc_wdata_r, comm_error_counter_r;
   int          bad_count = 0;
   int          comparisons = 0;

   modbus_slave_access_log_and_errors u_dut (
      .clock, .resetn, .slave_addr(SA), .rx_data, .rx_valid, .rx_parity_err,
      .rx_framing_err, .rx_overrun_err, .rx_frame_end, .tx_ready, .acc_rdata,
      .acc_ok, .acc_value_bad, .tx_data_r, .tx_valid_r, .acc_req_r,
      .acc_we_r, .acc_addr_r, .acc_wdata_r, .comm_error_counter_r,
      .rx_error_r, .busy_r);
   modbus_master_model u_m (
      .clock, .slow, .tx_data_r, .tx_valid_r, .rx_data, .rx_valid,
      .rx_parity_err, .rx_framing_err, .rx_overrun_err, .rx_frame_end,
      .tx_ready);

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Back end: registers 03EE and 03EF exist as ok_mask says; others are
   // refused, and refused reads show junk the handler must not forward.
   wire         hit = (acc_addr_r - 16'h03EE) < 16'h0002
                      && ok_mask[acc_addr_r[0]];

   // Ok and read data come from one look-up, so a refused access can
   // never colour the data of the next. A write of FFFF is a bad value.
   always @(negedge clock)
      if (acc_req_r) begin
         acc_ok <= hit;
         acc_rdata <= hit ? 16'hBEEF : {acc_addr_r[7:0], 8'hA5};
         acc_value_bad <= acc_we_r && acc_wdata_r == 16'hFFFF;
      end

   ////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] x, y);
      comparisons++;
      if (x !== y) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, x, y);
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic run(input int err, input logic [7:0] x[$]);
      logic [15:0] c;
      int          i;
      u_m.got.delete();
      u_m.send(f, err);
      if (x.size() > 0) begin
         c = u_m.crc16(x);
         x.push_back(c[7:0]);
         x.push_back(c[15:8]);
      end
      repeat (4) @(negedge clock);
      for (i = 0; i < 3000 && (busy_r !== 1'b0 || u_m.got.size() < x.size());
           i++)
         @(negedge clock);
      if (i == 3000) begin
         bad_count++;
         $display("[ERR] reply wait expected done seen timeout");
         wrap_up();
      end
      check("reply length", x.size(), u_m.got.size());
      foreach (x[k])
         check("reply byte", x[k], k < u_m.got.size() ? u_m.got[k] : 8'hXX);
   endtask

   task automatic t_read_log;
      ok_mask = 2'b10;
      f = '{SA, 8'h03, 8'h03, 8'hEE, 8'h00, 8'h02};
      e = '{SA, 8'h03, 8'h04, 8'h00, 8'h00, 8'hBE, 8'hEF};
      run(0, e);
      check("write enable", 16'h0000, acc_we_r);
      check("access address", 16'h03EF, acc_addr_r);
      f = '{SA, 8'h46};
      e = '{SA, 8'h46, 8'h03, 8'hEF, 8'h00, 8'h01};
      run(0, e);
      $display("read and log test ended");
   endtask

   task automatic t_write_log;
      ok_mask = 2'b11;
      f = '{SA, 8'h10, 8'h03, 8'hEE, 8'h00, 8'h02, 8'h04, 8'h00, 8'h05,
            8'h00, 8'h0A};
      check("query crc", 16'h3D86, u_m.crc16(f));
      e = '{SA, 8'h10, 8'h03, 8'hEE, 8'h00, 8'h02};
      run(0, e);
      check("write data", 16'h000A, acc_wdata_r);
      check("write enable", 16'h0001, acc_we_r);
      f = '{SA, 8'h46};
      e = '{SA, 8'h46, 8'h03, 8'hEE, 8'h00, 8'h02};
      run(0, e);
      $display("write and log test ended");
   endtask

   task automatic t_errors;
      slow = 1'b1;
      ok_mask = 2'b00;
      f = '{SA, 8'h07};
      run(0, '{SA, 8'h87, 8'h01});
      f = '{SA, 8'h46};
      run(0, '{SA, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
      f = '{SA, 8'h03, 8'h03, 8'hEE, 8'h00, 8'h00};
      run(0, '{SA, 8'h83, 8'h03});
      f = '{SA, 8'h03, 8'h03, 8'hEE, 8'h00, 8'h02};
      run(0, '{SA, 8'h83, 8'h02});
      f = '{SA, 8'h10, 8'h03, 8'hEE, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
      run(0, '{SA, 8'h90, 8'h02});
      f = '{SA, 8'h10, 8'h03, 8'hEE, 8'h00, 8'h01, 8'h02, 8'hFF, 8'hFF};
      run(0, '{SA, 8'h90, 8'h03});
      slow = 1'b0;
      $display("exception test ended");
   endtask

   task automatic t_silent;
      logic [15:0] c0;
      for (int k = 1; k <= 5; k++) begin
         c0 = comm_error_counter_r;
         f = (k == 5) ? '{SA} : '{SA, 8'h03, 8'h03, 8'hEE, 8'h00, 8'h01};
         run(k % 5, none);
         check("error count", c0 + 16'h0001, comm_error_counter_r);
      end
      c0 = comm_error_counter_r;
      f = '{8'h00, 8'h07};
      run(0, none);
      check("error count", c0, comm_error_counter_r);
      $display("silent frame test ended");
   endtask

   initial begin
      repeat (16) @(negedge clock);
      resetn = 1'b1;
      repeat (4) @(negedge clock);
      t_read_log();
      t_write_log();
      t_errors();
      t_silent();
      wrap_up();
   end
endmodule
